/* File: rtl/usbep_cfg.svh */
// Purpose: offsets, field positions and counts of the endpoint block
// Assumes: 8-bit register port, byte addressed
// Notes: definitions only
`ifndef USBEP_CFG_SVH
`define USBEP_CFG_SVH
`define USBEP_OFF_CFG 8'h1F
`define USBEP_OFF_A0 8'h12
`define USBEP_OFF_A1 8'h14
`define USBEP_OFF_A2 8'h16
`define USBEP_OFF_B0 8'h42
`define USBEP_OFF_B1 8'h44
`define USBEP_CFG_SIZE 7
`define USBEP_CFG_ONE 6
`define USBEP_BIT_SETUP 7
`define USBEP_BIT_IN 6
`define USBEP_BIT_OUT 5
`define USBEP_BIT_ACK 4
`define USBEP_MODE_DIS 4'h0
`define USBEP_MODE_NAKIO 4'h1
`define USBEP_MODE_STOUT 4'h2
`define USBEP_MODE_STALL 4'h3
`define USBEP_MODE_IGN 4'h4
`define USBEP_MODE_ISOOUT 4'h5
`define USBEP_STALL_PER_BYTE 6'h03
`define USBEP_MASK_8 5'h07
`define USBEP_MASK_32 5'h1F
`define USBEP_S0_BASE0 8'hF8
`define USBEP_S0_BASE1 8'hF0
`define USBEP_S0_BASE2 8'hE8
`define USBEP_S0_BASE3 8'hE0
`define USBEP_S0_BASE4 8'hD8
`define USBEP_S1_BASE0 8'hB8
`define USBEP_S1_BASE1 8'hC0
`define USBEP_S1_BASE2 8'hE0
`define USBEP_S1_BASE3 8'hA8
`define USBEP_S1_BASE4 8'hB0
`endif

/* File: rtl/usbep_core.sv */
// Purpose: endpoint configuration and the five endpoint mode registers
// Assumes: serial engine events arrive as one-cycle pulses
// Notes: slots 0..2 are A0..A2, slot 3 is B0 or A3, slot 4 is B1 or A4
`include "usbep_cfg.svh"
module usbep_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  input wire usbep_pkg::usbep_ram_type cpu_mem,
  input wire usbep_pkg::usbep_evt_type evt,
  input wire usbep_pkg::usbep_fwr_type fwr,
  output usbep_pkg::usbep_resp_type resp,
  output logic resp_valid,
  output usbep_pkg::usbep_ram_type ram,
  output logic cpu_stall
);
  logic [1:0] cfg_r;
  logic [7:0] mode_r [5];
  logic [4:0] lock_r;
  logic [2:0] cur_slot_r;
  logic cur_ctrl_r;
  usbep_pkg::usbep_tok_type cur_kind_r;
  usbep_pkg::usbep_phase_type phase_r;
  usbep_pkg::usbep_phase_type phase_nxt;
  usbep_pkg::usbep_resp_type resp_r;
  usbep_pkg::usbep_resp_type tok_resp;
  usbep_pkg::usbep_ram_type ram_r;
  logic resp_valid_r;
  logic [7:0] rdata_r;
  logic [5:0] stall_cnt_r;
  logic [5:0] stall_cnt_nxt;
  logic stall_r;
  logic one_addr;
  logic big;
  logic [3:0] tok_sl;
  logic [3:0] fw_sl;
  logic [3:0] cpu_sl;
  logic [4:0] upd_v;
  logic [4:0] set_v;
  logic [4:0] cwr_v;
  logic [4:0] crd_v;
  logic refuse;

  assign one_addr = cfg_r[0];
  assign big = cfg_r[1];

  // Map address and endpoint number to a slot; bit 3 marks a valid slot
  function automatic logic [3:0] slot_of(input logic b, input logic [2:0] ep, input logic one);
    logic [3:0] s;
    s = 4'h0;
    if (one) begin
      s = {(!b && ep < 3'h5), ep};
    end else if (b) begin
      s = {(ep < 3'h2), ep + 3'h3};
    end else begin
      s = {(ep < 3'h3), ep};
    end
    return s;
  endfunction

  function automatic logic is_ctrl(input logic [2:0] s, input logic one);
    return (s == 3'h0) || (s == 3'h3 && !one);
  endfunction

  // FIFO start in user RAM; placement depends only on the slot and the size bit
  function automatic logic [7:0] fifo_base(input logic sz, input logic [2:0] s);
    logic [7:0] a;
    a = 8'h00;
    unique case (s)
      3'h0: a = sz ? `USBEP_S1_BASE0 : `USBEP_S0_BASE0;
      3'h1: a = sz ? `USBEP_S1_BASE1 : `USBEP_S0_BASE1;
      3'h2: a = sz ? `USBEP_S1_BASE2 : `USBEP_S0_BASE2;
      3'h3: a = sz ? `USBEP_S1_BASE3 : `USBEP_S0_BASE3;
      default: a = sz ? `USBEP_S1_BASE4 : `USBEP_S0_BASE4;
    endcase
    return a;
  endfunction

  function automatic logic [3:0] reg_slot(input logic [7:0] a);
    logic [3:0] s;
    s = 4'h0;
    case (a)
      `USBEP_OFF_A0: s = 4'h8;
      `USBEP_OFF_A1: s = 4'h9;
      `USBEP_OFF_A2: s = 4'hA;
      `USBEP_OFF_B0: s = 4'hB;
      `USBEP_OFF_B1: s = 4'hC;
      default: s = 4'h0;
    endcase
    return s;
  endfunction

  // Handshake chosen from the mode field
  function automatic usbep_pkg::usbep_resp_type resp_of(
    input logic [3:0] m, input usbep_pkg::usbep_tok_type k, input logic ctrl);
    usbep_pkg::usbep_resp_type r;
    logic su;
    su = (k == usbep_pkg::USBEP_TK_SETUP);
    r = usbep_pkg::USBEP_RS_NAK;
    case (m)
      `USBEP_MODE_DIS: r = usbep_pkg::USBEP_RS_IGNORE;
      `USBEP_MODE_NAKIO: r = su ? usbep_pkg::USBEP_RS_ACK : usbep_pkg::USBEP_RS_NAK;
      `USBEP_MODE_STOUT: begin
        // Status stage accepts OUT; there is no variant that NAKs IN
        r = (k == usbep_pkg::USBEP_TK_IN) ? usbep_pkg::USBEP_RS_STALL : usbep_pkg::USBEP_RS_ACK;
      end
      `USBEP_MODE_STALL: r = su ? usbep_pkg::USBEP_RS_ACK : usbep_pkg::USBEP_RS_STALL;
      `USBEP_MODE_IGN: r = su ? usbep_pkg::USBEP_RS_ACK : usbep_pkg::USBEP_RS_IGNORE;
      `USBEP_MODE_ISOOUT: begin
        r = (k == usbep_pkg::USBEP_TK_OUT) ? usbep_pkg::USBEP_RS_ACK : usbep_pkg::USBEP_RS_IGNORE;
      end
      default: r = usbep_pkg::USBEP_RS_NAK;
    endcase
    if (su && !ctrl) begin
      r = usbep_pkg::USBEP_RS_IGNORE;
    end
    return r;
  endfunction

  assign tok_sl = slot_of(evt.addr_b, evt.ep, one_addr);
  assign fw_sl = slot_of(fwr.addr_b, fwr.ep, one_addr);
  assign cpu_sl = reg_slot(cpu_addr);
  assign tok_resp = resp_of(mode_r[tok_sl[2:0]][3:0], evt.kind, is_ctrl(tok_sl[2:0], one_addr));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= 2'h0;
    end else if (cpu_wr && cpu_addr == `USBEP_OFF_CFG) begin
      cfg_r <= {cpu_wdata[`USBEP_CFG_SIZE], cpu_wdata[`USBEP_CFG_ONE]};
    end
  end

  // Token answer, one cycle after the token
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_r <= usbep_pkg::USBEP_RS_IGNORE;
      resp_valid_r <= 1'b0;
    end else begin
      resp_valid_r <= evt.tok;
      resp_r <= tok_sl[3] ? tok_resp : usbep_pkg::USBEP_RS_IGNORE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_slot_r <= 3'h0;
      cur_ctrl_r <= 1'b0;
      cur_kind_r <= usbep_pkg::USBEP_TK_OUT;
    end else if (evt.tok) begin
      cur_slot_r <= tok_sl[2:0];
      cur_ctrl_r <= is_ctrl(tok_sl[2:0], one_addr);
      cur_kind_r <= evt.kind;
    end
  end

  // Transaction phase; FORCE spans SETUP data start to ACK start
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      usbep_pkg::USBEP_PH_IDLE: begin
        if (evt.tok && tok_sl[3] && tok_resp != usbep_pkg::USBEP_RS_IGNORE) begin
          phase_nxt = usbep_pkg::USBEP_PH_BUSY;
        end
      end
      usbep_pkg::USBEP_PH_BUSY: begin
        if (evt.update) begin
          phase_nxt = usbep_pkg::USBEP_PH_IDLE;
        end else if (evt.data_start && cur_ctrl_r && cur_kind_r == usbep_pkg::USBEP_TK_SETUP) begin
          phase_nxt = usbep_pkg::USBEP_PH_FORCE;
        end
      end
      usbep_pkg::USBEP_PH_FORCE: begin
        if (evt.ack_start || evt.update) begin
          phase_nxt = evt.update ? usbep_pkg::USBEP_PH_IDLE : usbep_pkg::USBEP_PH_BUSY;
        end
      end
      default: phase_nxt = usbep_pkg::USBEP_PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= usbep_pkg::USBEP_PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_slot
      localparam logic [2:0] SL = 3'(gi);
      logic ctrl;
      logic [7:0] m_nxt;
      assign ctrl = is_ctrl(SL, one_addr);
      assign upd_v[gi] = evt.update && phase_r != usbep_pkg::USBEP_PH_IDLE && cur_slot_r == SL;
      assign set_v[gi] = ctrl && cur_slot_r == SL && phase_nxt == usbep_pkg::USBEP_PH_FORCE;
      assign cwr_v[gi] = cpu_wr && cpu_sl[3] && cpu_sl[2:0] == SL;
      assign crd_v[gi] = cpu_rd && cpu_sl[3] && cpu_sl[2:0] == SL;

      always_comb begin
        m_nxt = mode_r[gi];
        if (cwr_v[gi]) begin
          if (!ctrl) begin
            m_nxt = cpu_wdata;
          end else begin
            if (!lock_r[gi]) begin
              m_nxt[6:0] = cpu_wdata[6:0];
            end
            m_nxt[`USBEP_BIT_SETUP] = 1'b0;
          end
        end
        if (upd_v[gi]) begin
          if (evt.acked) begin
            m_nxt[`USBEP_BIT_ACK] = 1'b1;
          end
          if (ctrl && cur_kind_r == usbep_pkg::USBEP_TK_OUT) begin
            m_nxt[`USBEP_BIT_OUT] = 1'b1;
          end
          if (ctrl && cur_kind_r == usbep_pkg::USBEP_TK_IN) begin
            m_nxt[`USBEP_BIT_IN] = 1'b1;
          end
          if (ctrl && cur_kind_r == usbep_pkg::USBEP_TK_SETUP && mode_r[gi][3:0] != `USBEP_MODE_DIS) begin
            m_nxt[3:0] = `USBEP_MODE_NAKIO;
          end
        end
        if (set_v[gi]) begin
          m_nxt[`USBEP_BIT_SETUP] = 1'b1;
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mode_r[gi] <= 8'h00;
        end else begin
          mode_r[gi] <= m_nxt;
        end
      end

      // Update of a control slot locks, a later read unlocks; the update wins a tie
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          lock_r[gi] <= 1'b0;
        end else if (upd_v[gi] && ctrl) begin
          lock_r[gi] <= 1'b1;
        end else if (crd_v[gi] || !ctrl) begin
          lock_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (cpu_rd && cpu_sl[3]) begin
      rdata_r <= mode_r[cpu_sl[2:0]];
    end else if (cpu_rd && cpu_addr == `USBEP_OFF_CFG) begin
      rdata_r <= {cfg_r, 6'h00};
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // CPU writes into a control FIFO are dropped while its setup bit is up
  assign refuse = cpu_mem.we && (
    ({cpu_mem.addr[7:3], 3'h0} == fifo_base(big, 3'h0) && mode_r[0][`USBEP_BIT_SETUP]) ||
    (!one_addr && {cpu_mem.addr[7:3], 3'h0} == fifo_base(big, 3'h3) && mode_r[3][`USBEP_BIT_SETUP]));

  // Engine owns the RAM bus while it writes a received byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_r <= '0;
    end else if (fwr.valid && fw_sl[3]) begin
      ram_r.we <= 1'b1;
      ram_r.data <= fwr.data;
      ram_r.addr <= fifo_base(big, fw_sl[2:0]) + {3'h0, fwr.off & ((big && (fw_sl[2:0] == 3'h1 ||
        fw_sl[2:0] == 3'h2)) ? `USBEP_MASK_32 : `USBEP_MASK_8)};
    end else begin
      ram_r.we <= cpu_mem.we && !refuse;
      ram_r.data <= cpu_mem.data;
      ram_r.addr <= cpu_mem.addr;
    end
  end

  always_comb begin
    stall_cnt_nxt = stall_cnt_r - {5'h00, (stall_cnt_r != 6'h00)};
    if (fwr.valid && fw_sl[3]) begin
      stall_cnt_nxt = stall_cnt_nxt + `USBEP_STALL_PER_BYTE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_r <= 6'h00;
      stall_r <= 1'b0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
      stall_r <= stall_cnt_nxt != 6'h00;
    end
  end

  assign cpu_rdata = rdata_r;
  assign resp = resp_r;
  assign resp_valid = resp_valid_r;
  assign ram = ram_r;
  assign cpu_stall = stall_r;

  sequence s_first_byte;
    fwr.valid && fw_sl[3] && stall_cnt_r == 6'h00;
  endsequence
  property p_stall_three;
    @(posedge ref_clk) disable iff (!rst_n)
    s_first_byte |=> cpu_stall[*3];
  endproperty
  a_stall_three: assert property (p_stall_three) else $error("stall shorter than three cycles");

  sequence s_force_start;
    phase_r == usbep_pkg::USBEP_PH_BUSY && phase_nxt == usbep_pkg::USBEP_PH_FORCE;
  endsequence
  property p_setup_held;
    @(posedge ref_clk) disable iff (!rst_n)
    s_force_start ##1 (phase_r == usbep_pkg::USBEP_PH_FORCE) |-> mode_r[cur_slot_r][`USBEP_BIT_SETUP];
  endproperty
  a_setup_held: assert property (p_setup_held) else $error("setup bit low while forced");

  property p_write_clears_setup;
    @(posedge ref_clk) disable iff (!rst_n)
    cwr_v[0] && !set_v[0] && is_ctrl(3'h0, one_addr) |=> !mode_r[0][`USBEP_BIT_SETUP];
  endproperty
  a_write_clears_setup: assert property (p_write_clears_setup) else $error("CPU write left setup bit");

  property p_lock_blocks;
    @(posedge ref_clk) disable iff (!rst_n)
    lock_r[0] && cwr_v[0] && !upd_v[0] |=> mode_r[0][6:0] == $past(mode_r[0][6:0]);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked bits changed by CPU");

  property p_read_unlocks;
    @(posedge ref_clk) disable iff (!rst_n)
    crd_v[0] && !upd_v[0] |=> !lock_r[0];
  endproperty
  a_read_unlocks: assert property (p_read_unlocks) else $error("read did not unlock");

  property p_lock_ctrl_only;
    @(posedge ref_clk) disable iff (!rst_n)
    !lock_r[1] && !lock_r[2] && !lock_r[4] && (!(one_addr && $past(one_addr)) || !lock_r[3]);
  endproperty
  a_lock_ctrl_only: assert property (p_lock_ctrl_only) else $error("non-control register locked");

  property p_disabled_ignores;
    @(posedge ref_clk) disable iff (!rst_n)
    evt.tok && mode_r[tok_sl[2:0]][3:0] == `USBEP_MODE_DIS |=> resp_valid && resp == usbep_pkg::USBEP_RS_IGNORE;
  endproperty
  a_disabled_ignores: assert property (p_disabled_ignores) else $error("disabled endpoint answered");

  property p_setup_nakio;
    @(posedge ref_clk) disable iff (!rst_n)
    upd_v[0] && is_ctrl(3'h0, one_addr) && cur_kind_r == usbep_pkg::USBEP_TK_SETUP
      |=> mode_r[0][3:0] == `USBEP_MODE_NAKIO;
  endproperty
  a_setup_nakio: assert property (p_setup_nakio) else $error("SETUP did not force NAK mode");

  property p_fifo_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
    refuse && !fwr.valid |=> !ram.we;
  endproperty
  a_fifo_refuse: assert property (p_fifo_refuse) else $error("FIFO write passed under setup");

  property p_ack_flag;
    @(posedge ref_clk) disable iff (!rst_n)
    upd_v[1] && evt.acked |=> mode_r[1][`USBEP_BIT_ACK];
  endproperty
  a_ack_flag: assert property (p_ack_flag) else $error("ACK flag not set");
endmodule

/* File: rtl/usbep_pkg.sv */
// Purpose: types of the endpoint block
// Assumes: nothing
// Notes: constants live in usbep_cfg.svh
package usbep_pkg;
  typedef enum logic [1:0] {
    USBEP_TK_OUT = 2'h0,
    USBEP_TK_IN = 2'h1,
    USBEP_TK_SETUP = 2'h2
  } usbep_tok_type;
  typedef enum logic [1:0] {
    USBEP_RS_IGNORE = 2'h0,
    USBEP_RS_ACK = 2'h1,
    USBEP_RS_NAK = 2'h2,
    USBEP_RS_STALL = 2'h3
  } usbep_resp_type;
  typedef enum logic [2:0] {
    USBEP_PH_IDLE = 3'h1,
    USBEP_PH_BUSY = 3'h2,
    USBEP_PH_FORCE = 3'h4
  } usbep_phase_type;
  typedef struct packed {
    logic tok;
    usbep_tok_type kind;
    logic addr_b;
    logic [2:0] ep;
    logic data_start;
    logic ack_start;
    logic update;
    logic acked;
  } usbep_evt_type;
  typedef struct packed {
    logic valid;
    logic addr_b;
    logic [2:0] ep;
    logic [4:0] off;
    logic [7:0] data;
  } usbep_fwr_type;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } usbep_ram_type;
endpackage

/* File: test/testbench.sv */
// Purpose: register port and engine event tests of the endpoint block
// Assumes: register answers and FIFO writes appear one cycle after the request
// Notes: expected values come from the FIFO map and the mode register layout
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst_n;
  logic [7:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_wr;
  logic cpu_rd;
  logic [7:0] cpu_rdata;
  logic resp_valid;
  logic cpu_stall;
  usbep_pkg::usbep_ram_type cpu_mem;
  usbep_pkg::usbep_ram_type ram;
  usbep_pkg::usbep_evt_type evt;
  usbep_pkg::usbep_fwr_type fwr;
  usbep_pkg::usbep_resp_type resp;
  int err_total = 0;
  int compares = 0;
  int stall_n = 0;
  logic [7:0] base_s0 [5] = '{8'hF8, 8'hF0, 8'hE8, 8'hE0, 8'hD8};
  logic [7:0] base_s1 [5] = '{8'hB8, 8'hC0, 8'hE0, 8'hA8, 8'hB0};
  logic b;
  logic [2:0] ep;
  logic [7:0] exp_a;

  usbep_core u_usbep_core (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_mem(cpu_mem), .evt(evt), .fwr(fwr),
    .resp(resp), .resp_valid(resp_valid), .ram(ram), .cpu_stall(cpu_stall));
  usbep_host u_usbep_host (.ref_clk(ref_clk), .evt(evt), .fwr(fwr));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cpu_stall === 1'b1) stall_n <= stall_n + 1;
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    #1;
    chk(cpu_rdata, exp);
  endtask
  task automatic mem(input logic [7:0] a, input logic we_exp);
    @(posedge ref_clk);
    cpu_mem <= '{1'b1, a, 8'h11};
    @(posedge ref_clk);
    cpu_mem.we <= 1'b0;
    #1;
    chk({7'h0, ram.we}, {7'h0, we_exp});
  endtask
  task automatic tok(input usbep_pkg::usbep_tok_type k, input logic bb, input logic [2:0] e,
      input usbep_pkg::usbep_resp_type r);
    u_usbep_host.token(k, bb, e);
    #1;
    chk({7'h0, resp_valid}, 8'h01);
    chk({6'h0, resp}, {6'h0, r});
  endtask

  initial begin
    #400000;
    err_total++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_mem = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h12, 8'h00);
    rd(8'h42, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h44, 8'h00);
    rd(8'h1F, 8'h00);
    rd(8'h30, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h1F, {c[1:0], 6'h00});
      rd(8'h1F, {c[1:0], 6'h00});
      for (int s = 0; s < 5; s++) begin
        b = (c[0] == 1'b0) && (s > 2);
        ep = b ? 3'(s - 3) : 3'(s);
        exp_a = c[1] ? base_s1[s] : base_s0[s];
        exp_a = exp_a + ((c[1] && (s == 1 || s == 2)) ? 8'h0D : 8'h05);
        u_usbep_host.put(b, ep, 5'h0D, 8'h30 + 8'(s));
        #1;
        chk({7'h0, ram.we}, 8'h01);
        chk(ram.addr, exp_a);
        chk(ram.data, 8'h30 + 8'(s));
      end
    end
    wr(8'h1F, 8'h00);
    repeat (8) @(posedge ref_clk);
    #1;
    stall_n = 0;
    u_usbep_host.put(1'b0, 3'h0, 5'h01, 8'hC3);
    repeat (8) @(posedge ref_clk);
    chk(stall_n[7:0], 8'h03);
    #1;
    stall_n = 0;
    u_usbep_host.put(1'b0, 3'h1, 5'h02, 8'h3C);
    u_usbep_host.put(1'b0, 3'h1, 5'h03, 8'h3D);
    repeat (10) @(posedge ref_clk);
    chk(stall_n[7:0], 8'h06);
    tok(usbep_pkg::USBEP_TK_SETUP, 1'b0, 3'h0, usbep_pkg::USBEP_RS_IGNORE);
    u_usbep_host.mark(2'h3);
    rd(8'h12, 8'h00);
    wr(8'h12, 8'h02);
    rd(8'h12, 8'h02);
    tok(usbep_pkg::USBEP_TK_SETUP, 1'b0, 3'h0, usbep_pkg::USBEP_RS_ACK);
    u_usbep_host.gap = 4;
    u_usbep_host.mark(2'h0);
    u_usbep_host.gap = 0;
    rd(8'h12, 8'h82);
    mem(8'hF9, 1'b0);
    u_usbep_host.mark(2'h1);
    u_usbep_host.mark(2'h3);
    rd(8'h12, 8'h91);
    wr(8'h12, 8'h01);
    rd(8'h12, 8'h01);
    tok(usbep_pkg::USBEP_TK_IN, 1'b0, 3'h0, usbep_pkg::USBEP_RS_NAK);
    u_usbep_host.mark(2'h2);
    wr(8'h12, 8'h02);
    rd(8'h12, 8'h41);
    wr(8'h12, 8'h01);
    rd(8'h12, 8'h01);
    tok(usbep_pkg::USBEP_TK_OUT, 1'b0, 3'h0, usbep_pkg::USBEP_RS_NAK);
    u_usbep_host.mark(2'h2);
    rd(8'h12, 8'h21);
    mem(8'hF9, 1'b1);
    chk(ram.addr, 8'hF9);
    chk(ram.data, 8'h11);
    wr(8'h42, 8'h82);
    rd(8'h42, 8'h02);
    // Status-out mode accepts SETUP, so only the rule that a non-control slot ignores SETUP can refuse it
    wr(8'h14, 8'h02);
    rd(8'h14, 8'h02);
    tok(usbep_pkg::USBEP_TK_SETUP, 1'b0, 3'h1, usbep_pkg::USBEP_RS_IGNORE);
    tok(usbep_pkg::USBEP_TK_OUT, 1'b0, 3'h1, usbep_pkg::USBEP_RS_ACK);
    u_usbep_host.mark(2'h3);
    // Written with no read after the update: a lock would keep the old bits
    wr(8'h14, 8'h03);
    rd(8'h14, 8'h03);
    wr(8'h1F, 8'h40);
    wr(8'h42, 8'h82);
    rd(8'h42, 8'h82);
    // Reset in mid-run returns every register to zero
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h42, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h1F, 8'h00);
    close_out();
  end
endmodule

/* File: test/usbep_host.sv */
// Purpose: serial engine side model that issues tokens, phase marks and FIFO byte writes
// Assumes: all outputs change by non-blocking assignment right after a rising edge
// Notes: gap stretches the wait before each phase mark to mimic a slow host
module usbep_host (
  input wire logic ref_clk,
  output usbep_pkg::usbep_evt_type evt,
  output usbep_pkg::usbep_fwr_type fwr
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  initial begin
    evt = '0;
    fwr = '0;
    fwr.data = 8'h5A;
  end
  task automatic token(input usbep_pkg::usbep_tok_type k, input logic b, input logic [2:0] ep);
    @(posedge ref_clk);
    evt.tok <= 1'b1;
    evt.kind <= k;
    evt.addr_b <= b;
    evt.ep <= ep;
    @(posedge ref_clk);
    evt.tok <= 1'b0;
    // Address and endpoint qualifiers are not left showing the old token; kind keeps it
    evt.addr_b <= ~b;
    evt.ep <= ~ep;
  endtask
  // 0 data start, 1 ack start, 2 update, 3 update ending in ACK
  task automatic mark(input logic [1:0] w);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    evt.data_start <= (w == 2'h0);
    evt.ack_start <= (w == 2'h1);
    evt.update <= w[1];
    evt.acked <= (w == 2'h3);
    @(posedge ref_clk);
    evt.data_start <= 1'b0;
    evt.ack_start <= 1'b0;
    evt.update <= 1'b0;
    evt.acked <= 1'b0;
  endtask
  task automatic put(input logic b, input logic [2:0] ep, input logic [4:0] off, input logic [7:0] d);
    @(posedge ref_clk);
    fwr <= '{1'b1, b, ep, off, d};
    @(posedge ref_clk);
    fwr <= '{1'b0, ~b, ~ep, ~off, ~d};
  endtask
endmodule
